// *** rtl/dac_pll_config_sequence.v ***
// Host sequencer that programs the DAC clock synthesizer over the serial port
`include "pll_seq_consts.vh"

// How it works
// - Bypass select written 0x00 or 0x01
// - Bypass: two more writes, then stop
// - Companion A gets 0xFF bypass, 0x00 otherwise
// - Companion B gets all ones bypass, else 0x00
// - Fixed tuning writes in order, wait 100 ms
// - Pump current six bits, 0x04 to 0x10
// - Feedback divider written to bits 5:0
// - Predivider upper bits kept at 0x06
// - Phase detector between 25 and 770 MHz
// - Mid VCO band limits detector to 225 MHz
// - Exactly one VCO ratio select set
// - VCO reset 0x02, 0x00, wait, check lock
module dac_pll_config_sequence #(
  parameter PAUSE_CYCLES = `PAUSE_CYCLES,
  parameter SCLK_HALF = `SCLK_HALF_CYCLES
) (
  // Clock and reset
  input wire i_sys_clk,
  input wire i_rst_n,
  // User command
  input wire i_start,
  input wire i_bypass,
  input wire [5:0] i_pump_current_setting,
  input wire [1:0] i_adc_div_code,
  input wire [5:0] i_fb_div,
  input wire [1:0] i_predivide_code,
  input wire i_vco_half_select,
  input wire i_vco_third_select,
  input wire [10:0] i_ref_mhz,
  // User status
  output reg o_busy,
  output reg o_done,
  output reg o_cfg_error,
  output reg o_lock_fail,
  output reg o_locked,
  // Serial control port
  output wire o_cs_n,
  output wire o_sclk,
  output wire o_sdio_out,
  output wire o_sdio_oe,
  input wire i_sdio_in
);

  localparam [5:0] S_IDLE = 6'b00_0001;
  localparam [5:0] S_FETCH = 6'b00_0010;
  localparam [5:0] S_DECODE = 6'b00_0100;
  localparam [5:0] S_XFER = 6'b00_1000;
  localparam [5:0] S_PAUSE = 6'b01_0000;
  localparam [5:0] S_FIN = 6'b10_0000;

  reg [5:0] state_reg;
  reg [5:0] state_next;
  reg [4:0] step_reg;
  reg [4:0] step_next;
  reg [31:0] pause_reg;
  reg [31:0] pause_next;
  reg go_reg;
  reg go_next;
  reg read_reg;
  reg read_next;
  reg [11:0] addr_reg;
  reg [11:0] addr_next;
  reg [7:0] wdata_reg;
  reg [7:0] wdata_next;
  reg bypass_reg;
  reg [5:0] pump_reg;
  reg [7:0] div799_reg;
  reg [7:0] pre793_reg;
  reg [7:0] vco094_reg;
  reg [7:0] byte_sel;

  wire [`STEP_W-1:0] rom_data;
  wire [1:0] rom_op;
  wire [11:0] rom_addr;
  wire [2:0] rom_sel;
  wire [7:0] rom_val;
  wire spi_ready;
  wire spi_done;
  wire [7:0] spi_rdata;

  assign rom_op = rom_data[24:23];
  assign rom_addr = rom_data[22:11];
  assign rom_sel = rom_data[10:8];
  assign rom_val = rom_data[7:0];

  // Product of a figure and the predivide ratio, both kept at 32 bits
  function [31:0] times_ratio;
    input [31:0] figure;
    input [1:0] code;
    begin
      times_ratio = figure * ({30'd0, code} + 32'd1);
    end
  endfunction

  // Inclusive range test on a six-bit field
  function in_range;
    input [5:0] value;
    input [5:0] low;
    input [5:0] high;
    begin
      in_range = (value >= low) && (value <= high);
    end
  endfunction

  // Parameter check done at start; the device accepts nonsense silently
  function cfg_legal;
    input [5:0] pump;
    input [5:0] fb;
    input [1:0] code;
    input half;
    input third;
    input [10:0] ref_mhz;
    reg [31:0] ref32;
    reg [31:0] vco_x_m;
    reg mid_band;
    begin
      ref32 = {21'd0, ref_mhz};
      vco_x_m = `FB_SCALE * {26'd0, fb} * ref32;
      mid_band = (vco_x_m >= times_ratio(`VCO_MID_LO_MHZ, code)) &&
        (vco_x_m <= times_ratio(`VCO_MID_HI_MHZ, code));
      cfg_legal = in_range(pump, `PUMP_MIN, `PUMP_MAX) &&
        in_range(fb, `FB_DIV_MIN, `FB_DIV_MAX) &&
        (half ^ third) &&
        (ref32 >= times_ratio(`PFD_MIN_MHZ, code)) &&
        (ref32 <= times_ratio(`PFD_MAX_MHZ, code)) &&
        (!mid_band || (ref32 <= times_ratio(`PFD_MAX_MID_MHZ, code)));
    end
  endfunction

  wire cfg_ok = i_bypass |
    cfg_legal(i_pump_current_setting, i_fb_div, i_predivide_code, i_vco_half_select,
    i_vco_third_select, i_ref_mhz);

  seq_step_rom u_rom (
    .i_sys_clk(i_sys_clk),
    .i_addr(step_reg),
    .o_data(rom_data)
  );

  spi_xact #(
    .HALF(SCLK_HALF)
  ) u_spi (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_go(go_reg),
    .i_read(read_reg),
    .i_addr(addr_reg),
    .i_wdata(wdata_reg),
    .o_ready(spi_ready),
    .o_done(spi_done),
    .o_rdata(spi_rdata),
    .o_cs_n(o_cs_n),
    .o_sclk(o_sclk),
    .o_sdio_out(o_sdio_out),
    .o_sdio_oe(o_sdio_oe),
    .i_sdio_in(i_sdio_in)
  );

  // Data byte for the current step
  always @* begin
    case (rom_sel)
      `SEL_BYP_FLAG: byte_sel = bypass_reg ? `VAL_BYPASS_ON : `VAL_ZERO;
      `SEL_BYP_FILL: byte_sel = bypass_reg ? `VAL_BYPASS_FILL : `VAL_ZERO;
      `SEL_PUMP: byte_sel = {2'b00, pump_reg};
      `SEL_DIV799: byte_sel = div799_reg;
      `SEL_PRE793: byte_sel = pre793_reg;
      `SEL_VCO094: byte_sel = vco094_reg;
      default: byte_sel = rom_val;
    endcase
  end

  always @* begin
    state_next = state_reg;
    step_next = step_reg;
    pause_next = pause_reg;
    go_next = 1'b0;
    read_next = read_reg;
    addr_next = addr_reg;
    wdata_next = wdata_reg;
    case (state_reg)
      S_IDLE: begin
        step_next = 5'd0;
        if (i_start && cfg_ok) begin
          state_next = S_FETCH;
        end else if (i_start) begin
          state_next = S_FIN;
        end
      end
      S_FETCH: begin
        // Table read data lands one cycle after the step index
        state_next = S_DECODE;
      end
      S_DECODE: begin
        case (rom_op)
          `OP_WRITE, `OP_READ: begin
            if (spi_ready) begin
              go_next = 1'b1;
              read_next = (rom_op == `OP_READ);
              addr_next = rom_addr;
              wdata_next = byte_sel;
              state_next = S_XFER;
            end
          end
          `OP_PAUSE: begin
            pause_next = 32'd0;
            state_next = S_PAUSE;
          end
          default: state_next = S_FIN;
        endcase
      end
      S_XFER: begin
        if (spi_done) begin
          if (bypass_reg && step_reg == `STEP_BYPASS_LAST) begin
            state_next = S_FIN;
          end else begin
            step_next = step_reg + 5'd1;
            state_next = S_FETCH;
          end
        end
      end
      S_PAUSE: begin
        if (pause_reg == PAUSE_CYCLES - 1) begin
          step_next = step_reg + 5'd1;
          state_next = S_FETCH;
        end else begin
          pause_next = pause_reg + 32'd1;
        end
      end
      S_FIN: begin
        state_next = S_IDLE;
      end
      default: state_next = S_IDLE;
    endcase
  end

  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      state_reg <= S_IDLE;
      step_reg <= 5'd0;
      pause_reg <= 32'd0;
      go_reg <= 1'b0;
      read_reg <= 1'b0;
      addr_reg <= 12'h000;
      wdata_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      step_reg <= step_next;
      pause_reg <= pause_next;
      go_reg <= go_next;
      read_reg <= read_next;
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
    end
  end

  // Settings captured once so a mid-sequence change cannot mix values
  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      bypass_reg <= 1'b0;
      pump_reg <= 6'h00;
      div799_reg <= 8'h00;
      pre793_reg <= 8'h00;
      vco094_reg <= 8'h00;
    end else if (state_reg == S_IDLE && i_start) begin
      bypass_reg <= i_bypass;
      pump_reg <= i_pump_current_setting;
      div799_reg <= {i_adc_div_code, i_fb_div};
      pre793_reg <= {`PREDIV_UPPER, i_predivide_code};
      vco094_reg <= {6'h00, i_vco_third_select, i_vco_half_select};
    end
  end

  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_busy <= 1'b0;
      o_done <= 1'b0;
      o_cfg_error <= 1'b0;
      o_lock_fail <= 1'b0;
      o_locked <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (state_reg == S_IDLE && i_start) begin
        o_busy <= cfg_ok;
        o_cfg_error <= ~cfg_ok;
        o_lock_fail <= 1'b0;
        o_locked <= 1'b0;
      end
      if (state_reg == S_XFER && spi_done && read_reg) begin
        o_locked <= spi_rdata[`LOCK_BIT];
        o_lock_fail <= ~spi_rdata[`LOCK_BIT];
      end
      if (state_reg == S_FIN) begin
        o_busy <= 1'b0;
        o_done <= 1'b1;
      end
    end
  end

endmodule

// *** rtl/pll_seq_consts.vh ***
// Register map, values and timing for the DAC clock synthesizer setup sequencer
`ifndef PLL_SEQ_CONSTS_VH
`define PLL_SEQ_CONSTS_VH

`define ADDR_SYNTH_BYPASS_SELECT 12'h095
`define ADDR_VCO_RATIO_SELECT 12'h094
`define ADDR_BYPASS_COMPANION_A 12'h790
`define ADDR_BYPASS_COMPANION_B 12'h791
`define ADDR_VCO_RESET 12'h792
`define ADDR_REFERENCE_PREDIVIDE_CFG 12'h793
`define ADDR_PUMP_CURRENT_CFG 12'h794
`define ADDR_SYNTH_TUNING_A 12'h796
`define ADDR_SYNTH_TUNING_B 12'h797
`define ADDR_SYNTH_TUNING_C 12'h798
`define ADDR_FEEDBACK_AND_OUTCLK_DIVIDE 12'h799
`define ADDR_SYNTH_TUNING_D 12'h7A0
`define ADDR_SYNTH_TUNING_E 12'h7A2
`define ADDR_LOCK_STATUS 12'h7B5

`define VAL_ZERO 8'h00
`define VAL_BYPASS_ON 8'h01
`define VAL_BYPASS_FILL 8'hFF
`define VAL_TUNING_A 8'hE5
`define VAL_TUNING_D 8'hBC
`define VAL_TUNING_B1 8'h10
`define VAL_TUNING_B2 8'h20
`define VAL_TUNING_C 8'h10
`define VAL_TUNING_E 8'h7F
`define VAL_VCO_RESET 8'h02
`define PREDIV_UPPER 6'h06
`define LOCK_BIT 0

`define PUMP_MIN 6'h04
`define PUMP_MAX 6'h10
`define FB_DIV_MIN 6'h02
`define FB_DIV_MAX 6'h32
`define PFD_MIN_MHZ 25
`define PFD_MAX_MHZ 770
`define PFD_MAX_MID_MHZ 225
`define VCO_MID_LO_MHZ 9960
`define VCO_MID_HI_MHZ 10870
`define FB_SCALE 8

`define CLK_KHZ 100000
`define PAUSE_MS 100
`define PAUSE_CYCLES (`PAUSE_MS * `CLK_KHZ)
`define SCLK_HALF_CYCLES 4

// Step table encoding
`define OP_WRITE 2'b00
`define OP_PAUSE 2'b01
`define OP_READ 2'b10
`define OP_END 2'b11
`define SEL_CONST 3'd0
`define SEL_BYP_FLAG 3'd1
`define SEL_BYP_FILL 3'd2
`define SEL_PUMP 3'd3
`define SEL_DIV799 3'd4
`define SEL_PRE793 3'd5
`define SEL_VCO094 3'd6
`define STEP_BYPASS_LAST 5'd2
`define STEP_COUNT 18
`define STEP_W 25

`endif

// *** rtl/seq_step_rom.v ***
// Step table of the synthesizer setup sequence with registered read data
`include "pll_seq_consts.vh"

module seq_step_rom (
  // Clock
  input wire i_sys_clk,
  // Read port
  input wire [4:0] i_addr,
  output reg [`STEP_W-1:0] o_data
);

  function [`STEP_W-1:0] step;
    input [1:0] op;
    input [11:0] addr;
    input [2:0] sel;
    input [7:0] val;
    begin
      step = {op, addr, sel, val};
    end
  endfunction

  always @(posedge i_sys_clk) begin
    case (i_addr)
      5'd0: o_data <= step(`OP_WRITE, `ADDR_SYNTH_BYPASS_SELECT, `SEL_BYP_FLAG, `VAL_ZERO);
      5'd1: o_data <= step(`OP_WRITE, `ADDR_BYPASS_COMPANION_A, `SEL_BYP_FILL, `VAL_ZERO);
      5'd2: o_data <= step(`OP_WRITE, `ADDR_BYPASS_COMPANION_B, `SEL_BYP_FILL, `VAL_ZERO);
      5'd3: o_data <= step(`OP_WRITE, `ADDR_SYNTH_TUNING_A, `SEL_CONST, `VAL_TUNING_A);
      5'd4: o_data <= step(`OP_WRITE, `ADDR_SYNTH_TUNING_D, `SEL_CONST, `VAL_TUNING_D);
      5'd5: o_data <= step(`OP_WRITE, `ADDR_PUMP_CURRENT_CFG, `SEL_PUMP, `VAL_ZERO);
      5'd6: o_data <= step(`OP_WRITE, `ADDR_SYNTH_TUNING_B, `SEL_CONST, `VAL_TUNING_B1);
      5'd7: o_data <= step(`OP_WRITE, `ADDR_SYNTH_TUNING_B, `SEL_CONST, `VAL_TUNING_B2);
      5'd8: o_data <= step(`OP_WRITE, `ADDR_SYNTH_TUNING_C, `SEL_CONST, `VAL_TUNING_C);
      5'd9: o_data <= step(`OP_WRITE, `ADDR_SYNTH_TUNING_E, `SEL_CONST, `VAL_TUNING_E);
      5'd10: o_data <= step(`OP_PAUSE, 12'h000, `SEL_CONST, `VAL_ZERO);
      5'd11: o_data <= step(`OP_WRITE, `ADDR_FEEDBACK_AND_OUTCLK_DIVIDE, `SEL_DIV799, `VAL_ZERO);
      5'd12: o_data <= step(`OP_WRITE, `ADDR_REFERENCE_PREDIVIDE_CFG, `SEL_PRE793, `VAL_ZERO);
      5'd13: o_data <= step(`OP_WRITE, `ADDR_VCO_RATIO_SELECT, `SEL_VCO094, `VAL_ZERO);
      5'd14: o_data <= step(`OP_WRITE, `ADDR_VCO_RESET, `SEL_CONST, `VAL_VCO_RESET);
      5'd15: o_data <= step(`OP_WRITE, `ADDR_VCO_RESET, `SEL_CONST, `VAL_ZERO);
      5'd16: o_data <= step(`OP_PAUSE, 12'h000, `SEL_CONST, `VAL_ZERO);
      5'd17: o_data <= step(`OP_READ, `ADDR_LOCK_STATUS, `SEL_CONST, `VAL_ZERO);
      default: o_data <= step(`OP_END, 12'h000, `SEL_CONST, `VAL_ZERO);
    endcase
  end

endmodule

// *** rtl/spi_xact.v ***
// Serial control port master: one 24-bit write or read, 3-wire, mode 0
`include "pll_seq_consts.vh"

module spi_xact #(
  parameter HALF = `SCLK_HALF_CYCLES
) (
  // Clock and reset
  input wire i_sys_clk,
  input wire i_rst_n,
  // Request
  input wire i_go,
  input wire i_read,
  input wire [11:0] i_addr,
  input wire [7:0] i_wdata,
  output wire o_ready,
  output reg o_done,
  output reg [7:0] o_rdata,
  // Pins
  output reg o_cs_n,
  output reg o_sclk,
  output wire o_sdio_out,
  output reg o_sdio_oe,
  input wire i_sdio_in
);

  reg sdio_meta_reg;
  reg sdio_sync_reg;
  reg [23:0] shift_reg;
  reg [4:0] bit_reg;
  reg [7:0] div_reg;
  reg read_reg;

  assign o_ready = o_cs_n & ~i_go;
  assign o_sdio_out = shift_reg[23];

  always @(posedge i_sys_clk) begin
    sdio_meta_reg <= i_sdio_in;
    sdio_sync_reg <= sdio_meta_reg;
  end

  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_cs_n <= 1'b1;
      o_sclk <= 1'b0;
      o_sdio_oe <= 1'b0;
      o_done <= 1'b0;
      o_rdata <= 8'h00;
      shift_reg <= 24'h00_0000;
      bit_reg <= 5'd0;
      div_reg <= 8'h00;
      read_reg <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (o_cs_n) begin
        if (i_go) begin
          // Instruction: R/W bit, then 15-bit address, then data
          shift_reg <= {i_read, 3'b000, i_addr, i_wdata};
          read_reg <= i_read;
          o_cs_n <= 1'b0;
          o_sdio_oe <= 1'b1;
          bit_reg <= 5'd0;
          div_reg <= 8'h00;
        end
      end else if (div_reg != HALF[7:0] - 8'h01) begin
        div_reg <= div_reg + 8'h01;
      end else begin
        div_reg <= 8'h00;
        if (!o_sclk) begin
          // Sampled late in the low phase so the synchroniser delay is covered
          o_sclk <= 1'b1;
          o_rdata <= {o_rdata[6:0], sdio_sync_reg};
        end else begin
          o_sclk <= 1'b0;
          if (bit_reg == 5'd23) begin
            o_cs_n <= 1'b1;
            o_sdio_oe <= 1'b0;
            o_done <= 1'b1;
          end else begin
            bit_reg <= bit_reg + 5'd1;
            shift_reg <= {shift_reg[22:0], 1'b0};
            o_sdio_oe <= ~(read_reg && bit_reg >= 5'd15);
          end
        end
      end
    end
  end

endmodule

// *** testbench/pll_seq_checker.sv ***
// Port assertions for the synthesizer setup sequencer
module pll_seq_checker #(
  parameter PAUSE_CYCLES = 20,
  parameter SCLK_HALF = 4
) (
  // Clock and reset
  input wire i_sys_clk,
  input wire i_rst_n,
  // Command and status
  input wire i_start,
  input wire o_busy,
  input wire o_done,
  input wire o_cfg_error,
  input wire o_lock_fail,
  input wire o_locked,
  // Serial port
  input wire o_cs_n,
  input wire o_sclk,
  input wire o_sdio_out,
  input wire o_sdio_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  // High phase fixed at four cycles, the bench's setting
  sequence sclk_high_phase;
    o_sclk [*4] ##1 !o_sclk;
  endsequence
  sequence done_once;
    o_done ##1 !o_done;
  endsequence
  a_sclk_half_period: assert property ($rose(o_sclk) |-> sclk_high_phase)
    else $error("sclk high phase has wrong length");
  a_done_single_pulse: assert property (o_done |-> done_once)
    else $error("done longer than one cycle");
  a_busy_ends_done: assert property ($fell(o_busy) |-> o_done)
    else $error("busy dropped without done");
  a_busy_needs_start: assert property ($rose(o_busy) |-> $past(i_start))
    else $error("busy rose without start");
  a_error_no_frame: assert property (o_cfg_error |-> o_cs_n && !o_busy)
    else $error("traffic despite config error");
  a_idle_port_quiet: assert property (!o_busy |-> o_cs_n && !o_sclk && !o_sdio_oe)
    else $error("serial port active while idle");
  a_frame_host_drives: assert property ($fell(o_cs_n) |-> o_sdio_oe && !o_sclk)
    else $error("frame opened without host drive");
  a_data_on_fall: assert property (!o_cs_n && o_sdio_oe && $past(o_sdio_oe)
    && $changed(o_sdio_out) |-> $fell(o_sclk))
    else $error("data changed off falling sclk");
  a_lock_outcome_one: assert property (!(o_locked && o_lock_fail)
    && !(o_cfg_error && (o_locked || o_lock_fail)))
    else $error("conflicting lock outcome");
endmodule

bind dac_pll_config_sequence pll_seq_checker #(.PAUSE_CYCLES(PAUSE_CYCLES), .SCLK_HALF(SCLK_HALF))
  pll_seq_checker_inst (.i_sys_clk, .i_rst_n, .i_start, .o_busy, .o_done, .o_cfg_error,
  .o_lock_fail, .o_locked, .o_cs_n, .o_sclk, .o_sdio_out, .o_sdio_oe);

// *** testbench/dev_model.sv ***
// Behavioural model of the device serial port and synthesizer registers
module dev_model (
  // Serial port
  input wire i_cs_n,
  input wire i_sclk,
  input wire i_sdio,
  // Lock state to report
  input wire i_lock,
  // Data drive
  output logic o_sdio,
  output logic o_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [23:0] sh;
  logic [7:0] rd;
  logic rf;
  int n;
  logic [7:0] regs [0:4095];
  logic [19:0] wlog [$];
  initial begin
    o_sdio = 0;
    o_oe = 0;
    n = 0;
    rf = 0;
  end
  always @(negedge i_cs_n) begin
    n = 0;
    rf = 0;
  end
  always @(posedge i_cs_n) o_oe = 0;
  always @(posedge i_sclk) begin
    sh = {sh[22:0], i_sdio};
    n = n + 1;
    if (n == 16) begin
      rf = sh[15];
      rd = (sh[11:0] == 12'h7B5) ? {7'h00, i_lock} : regs[sh[11:0]];
    end
    if (n == 24 && !sh[23]) begin
      regs[sh[19:8]] = sh[7:0];
      wlog.push_back(sh[19:0]);
    end
  end
  // Released line toggles so a stale level never reads as data
  always @(negedge i_sclk) begin
    o_oe = rf && n >= 16 && n < 24;
    o_sdio = o_oe ? rd[23 - n] : ~o_sdio;
  end
endmodule

// *** testbench/test_dac_pll_config_sequence.sv ***
// Self-checking bench for the synthesizer setup sequencer
module test_dac_pll_config_sequence;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_sys_clk, i_rst_n, i_start, i_bypass, i_vco_half_select, i_vco_third_select;
  logic lock, last, hh;
  logic [5:0] i_pump_current_setting, i_fb_div;
  logic [1:0] i_adc_div_code, i_predivide_code, mm;
  logic [10:0] i_ref_mhz;
  wire o_busy, o_done, o_cfg_error, o_lock_fail, o_locked, o_cs_n, o_sclk, o_sdio_out, o_sdio_oe;
  wire m_sdio, m_oe, sdio;
  int fail_count, check_count, pfd;
  logic [31:0] rng;
  localparam int PAUSE = 20;
  int gap = 0, pauses = 0;
  assign sdio = o_sdio_oe ? o_sdio_out : (m_oe ? m_sdio : ~last);
  dac_pll_config_sequence #(.PAUSE_CYCLES(PAUSE), .SCLK_HALF(4)) dac_pll_config_sequence_inst (
    .i_sys_clk, .i_rst_n, .i_start, .i_bypass, .i_pump_current_setting, .i_adc_div_code,
    .i_fb_div, .i_predivide_code, .i_vco_half_select, .i_vco_third_select, .i_ref_mhz,
    .o_busy, .o_done, .o_cfg_error, .o_lock_fail, .o_locked, .o_cs_n, .o_sclk,
    .o_sdio_out, .o_sdio_oe, .i_sdio_in(sdio));
  dev_model dev_model_inst (.i_cs_n(o_cs_n), .i_sclk(o_sclk), .i_sdio(sdio), .i_lock(lock),
    .o_sdio(m_sdio), .o_oe(m_oe));
  initial begin
    i_sys_clk = 0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end
  always @(posedge i_sys_clk) last <= sdio;
  // A quiet port while busy that outlasts the pause length counts as one wait
  always @(posedge i_sys_clk) begin
    gap <= (o_cs_n && o_busy) ? gap + 1 : 0;
    if (gap == PAUSE) pauses <= pauses + 1;
  end
  function automatic logic [31:0] xorshift();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction
  function automatic logic cfg_bad(logic [5:0] p, logic [5:0] n, logic [1:0] m, logic h,
      logic t, int r);
    int d;
    d = m + 1;
    return p < 4 || p > 16 || n < 2 || n > 50 || h == t || r < 25 * d || r > 770 * d ||
      (8 * n * r >= 9960 * d && 8 * n * r <= 10870 * d && r > 225 * d);
  endfunction
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic run(string tn, logic b, logic [5:0] p, logic [1:0] a, logic [5:0] n,
      logic [1:0] m, logic h, logic t, logic [10:0] r, logic lk);
    logic [19:0] e [$];
    logic err;
    int k, p0;
    err = !b && cfg_bad(p, n, m, h, t, r);
    if (b) e = '{{12'h095, 8'h01}, {12'h790, 8'hFF}, {12'h791, 8'hFF}};
    else if (!err) e = '{{12'h095, 8'h00}, {12'h790, 8'h00}, {12'h791, 8'h00},
      {12'h796, 8'hE5}, {12'h7A0, 8'hBC}, {12'h794, 2'b00, p}, {12'h797, 8'h10},
      {12'h797, 8'h20}, {12'h798, 8'h10}, {12'h7A2, 8'h7F}, {12'h799, a, n},
      {12'h793, 6'h06, m}, {12'h094, 6'h00, t, h}, {12'h792, 8'h02}, {12'h792, 8'h00}};
    dev_model_inst.wlog.delete();
    p0 = pauses;
    i_bypass = b;
    i_pump_current_setting = p;
    i_adc_div_code = a;
    i_fb_div = n;
    i_predivide_code = m;
    i_vco_half_select = h;
    i_vco_third_select = t;
    i_ref_mhz = r;
    lock = lk;
    i_start = 1;
    @(posedge i_sys_clk) #1;
    i_start = 0;
    for (k = 0; k < 20000 && o_done !== 1'b1; k++) @(posedge i_sys_clk) #1;
    check({tn, " done"}, {o_done, o_busy}, 2'b10);
    check({tn, " error"}, o_cfg_error, err);
    check({tn, " locked"}, o_locked, !b && !err && lk);
    check({tn, " lock fail"}, o_lock_fail, !b && !err && !lk);
    check({tn, " frames"}, dev_model_inst.wlog.size(), e.size());
    check({tn, " pauses"}, pauses - p0, (b || err) ? 0 : 2);
    foreach (e[i]) check({tn, " write"}, dev_model_inst.wlog[i], e[i]);
    $display("Test %s finished", tn);
    repeat (2) @(posedge i_sys_clk);
    #1;
  endtask
  initial begin
    i_rst_n = 0;
    i_start = 0;
    i_bypass = 0;
    i_pump_current_setting = 6'h08;
    i_adc_div_code = 2'h0;
    i_fb_div = 6'h0A;
    i_predivide_code = 2'h0;
    i_vco_half_select = 1;
    i_vco_third_select = 0;
    i_ref_mhz = 11'h064;
    last = 0;
    lock = 1;
    rng = 84;
    fail_count = 0;
    check_count = 0;
    repeat (10) @(posedge i_sys_clk);
    #1 i_rst_n = 1;
    // Bypass ignores every other field, even illegal ones
    run("bypass", 1, 6'h3F, 2'h3, 6'h00, 2'h3, 1, 1, 11'h000, 0);
    for (int j = 0; j < 3; j++) begin
      mm = xorshift();
      hh = xorshift();
      pfd = 25 + xorshift() % 176;
      run("random", 0, 4 + xorshift() % 13, xorshift(), 2 + xorshift() % 49, mm, hh, !hh,
        pfd * (mm + 1), 1);
    end
    run("pump low lock fail", 0, 6'h04, 2'h0, 6'h02, 2'h0, 0, 1, 11'h019, 0);
    run("pump high edge", 0, 6'h10, 2'h3, 6'h32, 2'h1, 1, 0, 11'h604, 1);
    run("pump under", 0, 6'h03, 2'h0, 6'h0A, 2'h0, 1, 0, 11'h064, 1);
    run("pump over", 0, 6'h11, 2'h0, 6'h0A, 2'h0, 1, 0, 11'h064, 1);
    run("n under", 0, 6'h08, 2'h0, 6'h01, 2'h0, 1, 0, 11'h064, 1);
    run("n over", 0, 6'h08, 2'h0, 6'h33, 2'h0, 1, 0, 11'h064, 1);
    run("both selects", 0, 6'h08, 2'h0, 6'h0A, 2'h0, 1, 1, 11'h064, 1);
    run("pfd low", 0, 6'h08, 2'h0, 6'h0A, 2'h0, 1, 0, 11'h018, 1);
    run("pfd high", 0, 6'h08, 2'h0, 6'h0A, 2'h0, 1, 0, 11'h0303, 1);
    run("mid band", 0, 6'h08, 2'h0, 6'h05, 2'h0, 1, 0, 11'h0FA, 1);
    // Reset in mid-frame must return the port to idle at once
    i_fb_div = 6'h0A;
    i_start = 1;
    @(posedge i_sys_clk) #1;
    i_start = 0;
    repeat (40) @(posedge i_sys_clk) #1;
    check("mid-run busy", {o_busy, o_cs_n}, 2'h2);
    i_rst_n = 0;
    @(posedge i_sys_clk) #1;
    check("reset port", {o_cs_n, o_sclk, o_sdio_oe, o_sdio_out, o_busy, o_done}, 6'h20);
    @(posedge i_sys_clk) #1;
    i_rst_n = 1;
    run("after reset", 1, 6'h08, 2'h0, 6'h0A, 2'h0, 1, 0, 11'h064, 1);
    conclude();
  end
  initial begin
    #400_000;
    fail_count++;
    $display("Watchdog expired");
    conclude();
  end
endmodule
